// >>> hw/ilcr_pkg.sv
/*
 Shared constants for the input link command responder: opcodes, limits,
 support-mask layout, repeat timing and the responder state type.
 Assumes a 125 MHz core clock.
*/
package ilcr_pkg;
   // Command opcodes as they appear in the eight-bit frame field.
   localparam logic [7:0] OP_DATA_POLL            = 8'h10;
   localparam logic [7:0] OP_DATA_REPOLL          = 8'h20;
   localparam logic [7:0] OP_NAME_REPORT          = 8'h30;
   localparam logic [7:0] OP_AUTOREPEAT_DISABLE   = 8'h3d;
   localparam logic [7:0] OP_AUTOREPEAT_ENABLE_SLOW = 8'h3e;
   localparam logic [7:0] OP_AUTOREPEAT_ENABLE_FAST = 8'h3f;
   // Opcode split: upper nibble is the group, lower nibble the count.
   localparam int         GRP_LSB   = 4;
   localparam int         CNT_W     = 4;
   localparam int         KIND_W    = 2;
   // Most data frames one poll or report may carry.
   localparam logic [3:0] MAX_DATA  = 4'hf;
   localparam logic [2:0] ADDR_ALL  = 3'h0;
   // Cursor keys repeat with this fixed keycode.
   localparam logic [7:0] CURSOR_REPEAT_CODE = 8'h02;
   // Support mask: one bit per report kind, then auto-repeat.
   localparam int         SUP_W      = 5;
   localparam int         SUP_REPEAT = 4;
   // Repeat timing in nanoseconds and derived cycle counts.
   localparam int CLK_PERIOD_NS   = 8;
   localparam int REPEAT_DELAY_NS = 200_000_000;
   localparam int SLOW_PERIOD_NS  = 33_333_333;
   localparam int FAST_PERIOD_NS  = 16_666_666;
   localparam int DELAY_CYC_DEF =
      (REPEAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SLOW_CYC_DEF  = SLOW_PERIOD_NS / CLK_PERIOD_NS;
   localparam int FAST_CYC_DEF  = FAST_PERIOD_NS / CLK_PERIOD_NS;
   localparam int REP_CW        = 25;
   // Responder sequencing.
   typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_RPT, ST_CMD} ilcr_state_t;
endpackage

// >>> hw/ilcr_if.sv
/*
 Internal carriers: record memory port and auto-repeat control.
 Assumes all users share one clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface ilcr_mem_if #(parameter int AW = 5, parameter int DW = 8);
   logic          we;   // Write strobe.
   logic [AW-1:0] wa;   // Write address.
   logic [DW-1:0] wd;   // Write data.
   logic [AW-1:0] ra;   // Read address.
   logic [DW-1:0] rd;   // Registered read data.
   modport host (output we, wa, wd, ra, input rd);
   modport mem  (input we, wa, wd, ra, output rd);
endinterface

interface ilcr_rep_if;
   logic       enable;  // Auto-repeat switched on.
   logic       fast;    // Cursor keys at the fast rate.
   logic       ev;      // One-cycle repeat report.
   logic [7:0] code;    // Keycode of that report.
   modport ctl (output enable, fast, input ev, code);
   modport eng (input enable, fast, output ev, code);
endinterface
`default_nettype wire

// >>> hw/ilcr_rec_mem.sv
/*
 Two-bank record store with registered read data.
 Assumes one writer and one reader on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module ilcr_rec_mem
#(
   parameter int AW = 5,
   parameter int DW = 8
)
(
   input  wire logic clk_i,
   input  wire logic ce_i,
   ilcr_mem_if.mem   port
);
   // Storage array; no reset, contents only matter once written.
   logic [DW-1:0] mem_r [0:(1<<AW)-1];

   // Write and read on the same edge; read data lands a cycle later.
   always_ff @(posedge clk_i)
   begin
      if (ce_i)
      begin
         if (port.we)
            mem_r[port.wa] <= port.wd;
         port.rd <= mem_r[port.ra];
      end
   end
endmodule
`default_nettype wire

// >>> hw/ilcr_repeat.sv
/*
 Keyswitch auto-repeat engine: first report after the start delay, then
 one per period while the key stays down.
 Assumes key inputs are synchronous and steady per held key.
*/
`timescale 1ns/10ps
`default_nettype none
module ilcr_repeat
   import ilcr_pkg::*;
#(
   parameter int DELAY_CYC = DELAY_CYC_DEF,
   parameter int SLOW_CYC  = SLOW_CYC_DEF,
   parameter int FAST_CYC  = FAST_CYC_DEF
)
(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       ce_i,
   input  wire logic       key_down_i,
   input  wire logic [7:0] key_code_i,
   input  wire logic       key_cursor_i,
   input  wire logic       key_modifier_i,
   ilcr_rep_if.eng         rep
);
   logic [REP_CW-1:0] cnt_r;    // Cycles since the last report.
   logic              armed_r;  // Start delay has passed.
   logic [7:0]        hold_r;   // Key being timed.

   // Modifier keys never repeat; a new key restarts the delay.
   wire logic stop = !rep.enable || !key_down_i || key_modifier_i ||
                     (key_code_i != hold_r);
   wire logic [REP_CW-1:0] limit =
      !armed_r ? REP_CW'(DELAY_CYC) :
      (key_cursor_i && rep.fast) ? REP_CW'(FAST_CYC) : REP_CW'(SLOW_CYC);
   wire logic due = (cnt_r == limit - REP_CW'(1));

   // Count towards the next report and pulse when it falls due.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_r    <= '0;
         armed_r  <= 1'b0;
         hold_r   <= 8'h00;
         rep.ev   <= 1'b0;
         rep.code <= 8'h00;
      end
      else if (ce_i)
      begin
         rep.ev <= !stop && due;
         if (stop)
         begin
            cnt_r   <= '0;
            armed_r <= 1'b0;
            hold_r  <= key_code_i;
         end
         else if (due)
         begin
            cnt_r    <= '0;
            armed_r  <= 1'b1;
            rep.code <= key_cursor_i ? CURSOR_REPEAT_CODE : key_code_i;
         end
         else
            cnt_r <= cnt_r + REP_CW'(1);
      end
   end
endmodule
`default_nettype wire

// >>> hw/ilcr_top.sv
/*
 Input link command responder: answers poll, repoll, report and
 auto-repeat commands addressed to this device and passes all other
 commands that arrive while idle on unchanged.
 Assumes the link controller below delivers decoded frames one per cycle
 and accepts one returned frame per cycle.
*/
// Notes on behaviour
// - Poll answer: record, then opcode plus count.
// - Total poll data never exceeds fifteen bytes.
// - Only whole records are sent per poll.
// - Repoll resends the last poll record exactly.
// - Empty last poll means empty repoll.
// - Repoll opcode incremented like poll.
// - Name report returns ASCII text, then command.
// - Status report: one to fifteen bytes, command.
// - Extended describe: record then unchanged command.
// - Security report: header and identifier, command.
// - Disable stops repeats; command returned unchanged.
// - Auto-repeat starts disabled after reset.
// - Enable opcodes pick slow or fast cursor.
// - Report support advertised in describe data.
// - Unsupported command: drop data, forward unchanged.
// - Repeat after 200 ms, then 1/30 s.
`timescale 1ns/10ps
`default_nettype none
module ilcr_top
   import ilcr_pkg::*;
#(
   parameter int               DELAY_CYC = DELAY_CYC_DEF,
   parameter int               SLOW_CYC  = SLOW_CYC_DEF,
   parameter int               FAST_CYC  = FAST_CYC_DEF,
   parameter logic [SUP_W-1:0] SUPPORT   = 5'h1f
)
(
   input  wire logic       CLK_I,
   input  wire logic       RESET_N_I,
   input  wire logic       CE_I,
   input  wire logic [2:0] MY_ADDR_I,
   input  wire logic       FI_VALID_I,
   input  wire logic       FI_CMD_I,
   input  wire logic [2:0] FI_ADDR_I,
   input  wire logic [7:0] FI_BYTE_I,
   output var  logic       FO_VALID_O,
   output var  logic       FO_CMD_O,
   output var  logic [2:0] FO_ADDR_O,
   output var  logic [7:0] FO_BYTE_O,
   input  wire logic       REC_WR_I,
   input  wire logic [3:0] REC_IDX_I,
   input  wire logic [7:0] REC_BYTE_I,
   input  wire logic       REC_COMMIT_I,
   input  wire logic [3:0] REC_LEN_I,
   output var  logic       REC_FREE_O,
   output var  logic       REC_TAKEN_O,
   output var  logic       RPT_REQ_O,
   output var  logic [1:0] RPT_KIND_O,
   input  wire logic       RPT_VALID_I,
   input  wire logic       RPT_LAST_I,
   input  wire logic [7:0] RPT_BYTE_I,
   input  wire logic       KEY_DOWN_I,
   input  wire logic [7:0] KEY_CODE_I,
   input  wire logic       KEY_CURSOR_I,
   input  wire logic       KEY_MODIFIER_I,
   output var  logic       REP_VALID_O,
   output var  logic [7:0] REP_CODE_O,
   output var  logic       AR_ENABLED_O
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations.
   logic [1:0]  rst_pipe_r;    // Reset release synchroniser.
   wire  logic  rst_n = rst_pipe_r[1];
   ilcr_state_t state_r;       // Responder sequence.
   logic [7:0]  in_op_r;       // Command being answered.
   logic [2:0]  in_addr_r;     // Address field of that command.
   logic        count_up_r;    // Opcode grows with data sent.
   logic [3:0]  len_r;         // Frames to read from the store.
   logic [3:0]  idx_r;         // Frames issued or accepted so far.
   logic [3:0]  sent_r;        // Data frames already returned.
   logic        rd_pend_r;     // Store read data is valid now.
   logic        last_bank_r;   // Bank holding the last poll record.
   logic [3:0]  last_len_r;    // Length sent on the last poll.
   logic [3:0]  pend_len_r;    // Length of the waiting record.
   logic        ar_fast_r;     // Fast cursor rate selected.

   ilcr_mem_if #(.AW(5), .DW(8)) mem_if ();
   ilcr_rep_if                   rep_if ();

   // Group test used for both poll and repoll.
   function automatic logic in_group(input logic [7:0] op,
                                     input logic [7:0] base);
      in_group = (op[7:GRP_LSB] == base[7:GRP_LSB]);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Command decode.
   // Only command frames start a response; stray data frames are dropped.
   wire logic is_cmd = CE_I && FI_VALID_I && FI_CMD_I &&
                       (state_r == ST_IDLE);
   wire logic hit    = (FI_ADDR_I == ADDR_ALL) || (FI_ADDR_I == MY_ADDR_I);
   wire logic take   = is_cmd && hit;
   wire logic is_poll   = take && in_group(FI_BYTE_I, OP_DATA_POLL);
   wire logic is_repoll = take && in_group(FI_BYTE_I, OP_DATA_REPOLL);
   wire logic [1:0] kind = FI_BYTE_I[KIND_W-1:0];
   // Report opcodes share all bits above the kind field.
   wire logic is_rpt = take && SUPPORT[kind] &&
      (FI_BYTE_I[7:KIND_W] == OP_NAME_REPORT[7:KIND_W]);
   wire logic is_ar  = take && SUPPORT[SUP_REPEAT] &&
      (FI_BYTE_I >= OP_AUTOREPEAT_DISABLE) &&
      (FI_BYTE_I <= OP_AUTOREPEAT_ENABLE_FAST);
   // Room left under the fifteen-byte ceiling of this poll.
   wire logic [3:0] room = MAX_DATA - FI_BYTE_I[CNT_W-1:0];
   // A record goes out only whole, and only if it fits.
   wire logic poll_ok = !REC_FREE_O && (pend_len_r != 4'h0) &&
                        (pend_len_r <= room);
   wire logic rep_ok  = (last_len_r <= room);
   wire logic [3:0] send_len = is_poll   ? (poll_ok ? pend_len_r : 4'h0) :
                               is_repoll ? (rep_ok ? last_len_r : 4'h0) :
                               4'h0;
   // Returned opcode: count nibble raised by the data frames sent.
   wire logic [3:0] cnt_out = in_op_r[CNT_W-1:0] + sent_r;
   wire logic [7:0] cmd_out = count_up_r ?
      {in_op_r[7:GRP_LSB], cnt_out} : in_op_r;
   wire logic rpt_beat = CE_I && (state_r == ST_RPT) && RPT_VALID_I;
   wire logic rpt_end  = RPT_LAST_I || (idx_r == MAX_DATA - 4'h1);
   wire logic data_end = (idx_r == len_r - 4'h1);

   ////////////////////////////////////////////////////////////////////////
   // Reset release; the first stage feeds only the second.
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         rst_pipe_r <= 2'h0;
      else
         rst_pipe_r <= {rst_pipe_r[0], 1'b1};
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer. A command is taken only while idle, so commands that
   // arrive during an answer are ignored; the host waits for the return.
   always_ff @(posedge CLK_I or negedge rst_n)
   begin
      if (!rst_n)
         state_r <= ST_IDLE;
      else if (is_cmd)
         state_r <= is_rpt ? ST_RPT :
                    (send_len != 4'h0) ? ST_DATA : ST_CMD;
      else if (CE_I)
         unique case (state_r)
            ST_IDLE: state_r <= ST_IDLE;
            ST_DATA: state_r <= data_end ? ST_CMD : ST_DATA;
            ST_RPT:  state_r <= (rpt_beat && rpt_end) ? ST_CMD : ST_RPT;
            ST_CMD:  state_r <= rd_pend_r ? ST_CMD : ST_IDLE;
         endcase
   end

   // Latch the command and what is to be sent for it.
   always_ff @(posedge CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         in_op_r    <= 8'h00;
         in_addr_r  <= 3'h0;
         count_up_r <= 1'b0;
         len_r      <= 4'h0;
      end
      else if (is_cmd)
      begin
         in_op_r    <= FI_BYTE_I;
         in_addr_r  <= FI_ADDR_I;
         count_up_r <= is_poll || is_repoll;
         len_r      <= send_len;
      end
   end

   // Frame counters: issued reads or accepted report bytes, and frames out.
   always_ff @(posedge CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         idx_r     <= 4'h0;
         sent_r    <= 4'h0;
         rd_pend_r <= 1'b0;
      end
      else if (is_cmd)
      begin
         idx_r     <= 4'h0;
         sent_r    <= 4'h0;
         rd_pend_r <= 1'b0;
      end
      else if (CE_I)
      begin
         rd_pend_r <= (state_r == ST_DATA);
         if ((state_r == ST_DATA) || rpt_beat)
            idx_r <= idx_r + 4'h1;
         if (rd_pend_r || rpt_beat)
            sent_r <= sent_r + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Record banks. Software fills the free bank and commits it; a poll
   // that sends it makes it the last-poll bank kept for repolls.
   assign mem_if.we = CE_I && REC_WR_I && REC_FREE_O;
   assign mem_if.wa = {!last_bank_r, REC_IDX_I};
   assign mem_if.wd = REC_BYTE_I;
   assign mem_if.ra = {last_bank_r, idx_r};

   always_ff @(posedge CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         last_bank_r <= 1'b0;
         last_len_r  <= 4'h0;
         pend_len_r  <= 4'h0;
         REC_FREE_O  <= 1'b1;
         REC_TAKEN_O <= 1'b0;
      end
      else if (CE_I)
      begin
         REC_TAKEN_O <= is_poll && poll_ok;
         if (is_poll)
         begin
            // An empty poll also empties the repoll answer.
            last_len_r <= send_len;
            if (poll_ok)
            begin
               last_bank_r <= !last_bank_r;
               REC_FREE_O  <= 1'b1;
            end
         end
         // Commit is honoured only while the bank is free; a poll that
         // sends nothing in the same cycle must not swallow it.
         if (REC_COMMIT_I && REC_FREE_O && (REC_LEN_I != 4'h0))
         begin
            pend_len_r <= REC_LEN_I;
            REC_FREE_O <= 1'b0;
         end
      end
   end

   ilcr_rec_mem #(.AW(5), .DW(8)) u_mem
   (
      .clk_i (CLK_I),
      .ce_i  (CE_I),
      .port  (mem_if.mem)
   );

   ////////////////////////////////////////////////////////////////////////
   // Returned frames: store data or report data, then the command.
   always_ff @(posedge CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         FO_VALID_O <= 1'b0;
         FO_CMD_O   <= 1'b0;
         FO_ADDR_O  <= 3'h0;
         FO_BYTE_O  <= 8'h00;
      end
      else if (CE_I)
      begin
         FO_ADDR_O <= in_addr_r;
         FO_CMD_O  <= !(rd_pend_r || rpt_beat);
         FO_VALID_O <= rd_pend_r || rpt_beat || (state_r == ST_CMD);
         if (rd_pend_r)
            FO_BYTE_O <= mem_if.rd;
         else if (rpt_beat)
            FO_BYTE_O <= RPT_BYTE_I;
         else
            FO_BYTE_O <= cmd_out;
      end
   end

   // Report request towards the device's own data source.
   always_ff @(posedge CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         RPT_REQ_O  <= 1'b0;
         RPT_KIND_O <= 2'h0;
      end
      else if (CE_I)
      begin
         RPT_REQ_O <= is_rpt;
         if (is_rpt)
            RPT_KIND_O <= kind;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Auto-repeat control; off after reset until enabled.
   always_ff @(posedge CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         AR_ENABLED_O <= 1'b0;
         ar_fast_r    <= 1'b0;
      end
      else if (is_ar)
      begin
         AR_ENABLED_O <= (FI_BYTE_I != OP_AUTOREPEAT_DISABLE);
         ar_fast_r    <= (FI_BYTE_I == OP_AUTOREPEAT_ENABLE_FAST);
      end
   end

   assign rep_if.enable = AR_ENABLED_O;
   assign rep_if.fast   = ar_fast_r;
   assign REP_VALID_O   = rep_if.ev;
   assign REP_CODE_O    = rep_if.code;

   ilcr_repeat #(.DELAY_CYC(DELAY_CYC), .SLOW_CYC(SLOW_CYC),
                 .FAST_CYC(FAST_CYC)) u_rep
   (
      .clk_i          (CLK_I),
      .rst_n_i        (rst_n),
      .ce_i           (CE_I),
      .key_down_i     (KEY_DOWN_I),
      .key_code_i     (KEY_CODE_I),
      .key_cursor_i   (KEY_CURSOR_I),
      .key_modifier_i (KEY_MODIFIER_I),
      .rep            (rep_if.eng)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks, valid while the clock enable stays high.
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!rst_n || !CE_I);

   wire logic cmd_ret = FO_VALID_O && FO_CMD_O;

   // Poll and repoll return carries the count of frames sent.
   a_poll_count: assert property (cmd_ret && count_up_r |->
      FO_BYTE_O[3:0] == in_op_r[3:0] + sent_r)
      else $error("returned poll opcode does not match data count");
   a_poll_limit: assert property (count_up_r |->
      ({1'b0, in_op_r[3:0]} + {1'b0, sent_r}) <= {1'b0, MAX_DATA})
      else $error("poll data exceeds fifteen bytes");
   a_repoll_same: assert property (is_repoll && rep_ok |->
      ##1 len_r == last_len_r)
      else $error("repoll length differs from last poll");
   a_repoll_empty: assert property (is_repoll &&
      last_len_r == 4'h0 |=> state_r == ST_CMD)
      else $error("repoll sent data after an empty poll");
   a_rpt_unchanged: assert property (cmd_ret && !count_up_r
      |-> FO_BYTE_O == in_op_r)
      else $error("command not returned unchanged");
   a_ar_off: assert property (is_ar &&
      FI_BYTE_I == OP_AUTOREPEAT_DISABLE |=> ##1 !AR_ENABLED_O ##1
      !REP_VALID_O)
      else $error("repeat still active after disable");
   a_ar_fast: assert property (is_ar &&
      FI_BYTE_I == OP_AUTOREPEAT_ENABLE_FAST |=> AR_ENABLED_O && ar_fast_r)
      else $error("fast repeat not selected");
   a_ar_reset: assert property ($rose(rst_n) |-> !AR_ENABLED_O)
      else $error("auto-repeat on after reset");
   a_fwd_plain: assert property (is_cmd && !hit |->
      ##2 FO_VALID_O && FO_CMD_O && FO_BYTE_O == $past(FI_BYTE_I, 2))
      else $error("foreign command not forwarded unchanged");

   c_poll_data: cover property (is_poll && poll_ok ##[3:20] cmd_ret);
   c_repoll:    cover property (is_repoll && last_len_r != 4'h0);
   c_report:    cover property (is_rpt ##[2:40] cmd_ret);
   c_repeat:    cover property (REP_VALID_O);
endmodule
`default_nettype wire

// >>> verif/ilcr_host_model.sv
/*
 Host link controller model: sends frames and gathers the answer.
 Assumes one frame per cycle, taken at the rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module ilcr_host_model
(
   input  wire logic       clk_i,
   output var  logic       fi_valid_o,
   output var  logic       fi_cmd_o,
   output var  logic [2:0] fi_addr_o,
   output var  logic [7:0] fi_byte_o,
   input  wire logic       fo_valid_i,
   input  wire logic       fo_cmd_i,
   input  wire logic [2:0] fo_addr_i,
   input  wire logic [7:0] fo_byte_i
);
   logic [7:0] rx_q [$]; // Data bytes seen before the command.
   logic [7:0] rx_cmd;   // Returned opcode.
   logic [2:0] rx_addr;  // Returned address.
   logic       lost;     // Command did not return in time.
   ////////////////////////////////////////////////////////////////////
   // The link starts idle.
   initial
   begin
      {fi_valid_o, fi_cmd_o, fi_addr_o, fi_byte_o} = '0;
   end
   // Sends pre data frames and one command, then collects the answer.
   // The bound is far below the link timeout, as the block is quick.
   task automatic send(input logic [7:0] op, input logic [2:0] ad,
                       input int pre);
      rx_q.delete();
      lost = 1'b1;
      for (int i = 0; i <= pre; i++)
      begin
         @(posedge clk_i);
         #1;
         fi_valid_o = 1'b1;
         fi_cmd_o   = (i == pre);
         fi_addr_o  = ad;
         fi_byte_o  = (i == pre) ? op : 8'(i);
      end
      @(posedge clk_i);
      #1;
      // Released address and byte lines show the inverse; the command flag keeps its last value.
      fi_valid_o = 1'b0;
      fi_addr_o  = ~ad;
      fi_byte_o  = ~op;
      for (int n = 0; n < 200 && lost; n++)
      begin
         @(posedge clk_i);
         #1;
         if (fo_valid_i === 1'b1 && fo_cmd_i === 1'b1)
         begin
            rx_cmd  = fo_byte_i;
            rx_addr = fo_addr_i;
            lost    = 1'b0;
         end
         else if (fo_valid_i === 1'b1)
            rx_q.push_back(fo_byte_i);
      end
   endtask
endmodule
`default_nettype wire

// >>> verif/test_input_link_command_responder.sv
/*
 Bench for the responder: random records, reports and key repeats.
 Assumes the package, the design and the host model compile first.
*/
`timescale 1ns/10ps
`default_nettype none
module test_input_link_command_responder
   import ilcr_pkg::*;
;
   localparam logic [2:0] ME  = 3'h3; // Our match address.
   localparam int         DLY = 20;   // Shortened repeat delay.
   localparam int         SLW = 8;    // Shortened slow period.
   localparam int         FST = 4;    // Shortened fast period.
   localparam logic [7:0] OPS [3] = '{OP_AUTOREPEAT_ENABLE_SLOW,
      OP_AUTOREPEAT_ENABLE_FAST, OP_AUTOREPEAT_DISABLE};
   logic       clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
   logic       fv, fc, ov, oc, wr, cm, fr, tk, rq, rv, rl, kd, kc, km, pv, ae;
   logic [2:0] fa, oa;                   // Frame addresses.
   logic [7:0] fb, ob, wb, rb, kcode, pc; // Bytes of each port.
   logic [3:0] wi, wl;                   // Record index and length.
   logic [1:0] rk;                       // Report kind.
   logic [7:0] rec_q [$], exp_q [$];     // Record and expected data.
   int         error_cnt = 0, tests_run = 0, seed = 32'h1a5c, taken = 0;
   ////////////////////////////////////////////////////////////////////
   always #4 clk = ~clk;
   // Counts records handed over, to see each is taken exactly once.
   always @(posedge clk) if (tk === 1'b1) taken++;
   ilcr_top #(.DELAY_CYC(DLY), .SLOW_CYC(SLW), .FAST_CYC(FST)) DUT
   (
      .CLK_I(clk), .RESET_N_I(rst_n), .CE_I(ce), .MY_ADDR_I(ME),
      .FI_VALID_I(fv), .FI_CMD_I(fc), .FI_ADDR_I(fa), .FI_BYTE_I(fb),
      .FO_VALID_O(ov), .FO_CMD_O(oc), .FO_ADDR_O(oa), .FO_BYTE_O(ob),
      .REC_WR_I(wr), .REC_IDX_I(wi), .REC_BYTE_I(wb), .REC_COMMIT_I(cm),
      .REC_LEN_I(wl), .REC_FREE_O(fr), .REC_TAKEN_O(tk), .RPT_REQ_O(rq),
      .RPT_KIND_O(rk), .RPT_VALID_I(rv), .RPT_LAST_I(rl), .RPT_BYTE_I(rb),
      .KEY_DOWN_I(kd), .KEY_CODE_I(kcode), .KEY_CURSOR_I(kc),
      .KEY_MODIFIER_I(km), .REP_VALID_O(pv), .REP_CODE_O(pc),
      .AR_ENABLED_O(ae)
   );
   ilcr_host_model host
   (
      .clk_i(clk), .fi_valid_o(fv), .fi_cmd_o(fc), .fi_addr_o(fa),
      .fi_byte_o(fb), .fo_valid_i(ov), .fo_cmd_i(oc), .fo_addr_i(oa),
      .fo_byte_i(ob)
   );
   ////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      if (error_cnt == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // One command out; the data must match exp_q, then ret must return.
   task automatic cmd(input logic [7:0] op, input logic [2:0] ad,
                      input logic [7:0] ret, input int pre);
      host.send(op, ad, pre);
      check(16'(host.lost), 16'h0);
      if (host.lost === 1'b1)
         print_verdict();
      check(16'(host.rx_q.size()), 16'(exp_q.size()));
      foreach (exp_q[i])
         check(16'(host.rx_q[i]), 16'(exp_q[i]));
      check(16'({host.rx_addr, host.rx_cmd}), 16'({ad, ret}));
   endtask
   // Writes len random bytes into the free bank, then commits them.
   task automatic put_rec(input logic [3:0] len);
      rec_q.delete();
      for (int i = 0; i <= len; i++)
      begin
         @(posedge clk);
         #1;
         wr = (i < len);
         cm = (i == len);
         wi = 4'(i);
         wl = len;
         wb = 8'($random(seed));
         if (i < len)
            rec_q.push_back(wb);
      end
      @(posedge clk);
      #1;
      cm = 1'b0;
      check(16'(fr), 16'h0);
   endtask
   // Waits for a report request, then streams n random bytes.
   task automatic feed(input logic [1:0] kind, input int n);
      int w = 0;
      while (rq !== 1'b1 && w < 50)
      begin
         @(posedge clk);
         #1;
         w++;
      end
      check(16'({w < 50, rk}), 16'({1'b1, kind}));
      for (int i = 0; i < n; i++)
      begin
         rv = 1'b1;
         rl = (i == n - 1);
         rb = 8'($random(seed));
         exp_q.push_back(rb);
         @(posedge clk);
         #1;
      end
      rv = 1'b0;
      rb = ~rb;
   endtask
   // Holds a key; t1 and t2 are the cycles of the first two repeats.
   task automatic hold(input logic cur, input logic mdf,
                       output int t1, output int t2);
      {t1, t2} = '0;
      kcode = 8'($random(seed));
      {kc, km, kd} = {cur, mdf, 1'b1};
      for (int n = 1; n < 60 && t2 == 0; n++)
      begin
         @(posedge clk);
         #1;
         if (pv === 1'b1)
            check(16'(pc), 16'(cur ? CURSOR_REPEAT_CODE : kcode));
         if (pv === 1'b1 && t1 == 0)
            t1 = n;
         else if (pv === 1'b1)
            t2 = n;
      end
      kd = 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   // Repeat period after enable command k; 0 where no repeat may come.
   function automatic int gap(int k, logic cur, logic mdf);
      if (k > 1 || mdf)
         return 0;
      return (cur && k == 1) ? FST : SLW;
   endfunction
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      int t1, t2, g, k, up;
      logic [3:0] len;
      {wr, cm, rv, rl, kd, kc, km, wi, wl, wb, rb, kcode} = '0;
      repeat (5) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      check(16'({fr, ae, ov}), 16'h4);
      cmd(8'h47, ME, 8'h47, 2);
      exp_q.delete();
      cmd(OP_DATA_POLL, ADDR_ALL, OP_DATA_POLL, 0);
      // Records of random length; upstream room refused, exact, or free.
      for (int r = 0; r < 6; r++)
      begin
         len = 4'(2 + {$random(seed)} % 14);
         up  = (r % 2) ? 15 - len : 0;
         put_rec(len);
         exp_q.delete();
         if (r == 0)
            cmd(OP_DATA_REPOLL, ADDR_ALL, OP_DATA_REPOLL, 0);
         cmd(8'(32 - len), ADDR_ALL, 8'(32 - len), 0);
         check(16'(taken), 16'(r));
         exp_q = rec_q;
         cmd(8'(16 + up), ADDR_ALL, 8'(16 + up + len), 0);
         check(16'({fr, 8'(taken)}), 16'({1'b1, 8'(r + 1)}));
         cmd(8'(32 + up), ME, 8'(32 + up + len), 0);
      end
      for (int j = 0; j < 4; j++)
      begin
         exp_q.delete();
         up = 8'h30 + j;
         fork
            cmd(8'(up), ME, 8'(up), 0);
            feed(2'(j), 1 + {$random(seed)} % 15);
         join
      end
      exp_q.delete();
      cmd(OPS[1], 3'h5, OPS[1], 0);
      for (int i = 0; i < 4; i++)
      begin
         k = (i == 0) ? 3 : i - 1;
         if (i > 0)
            cmd(OPS[k], ME, OPS[k], 0);
         check(16'(ae), 16'(k < 2));
         for (int c = 0; c < 3; c++)
         begin
            hold(c == 1, c == 2, t1, t2);
            g = gap(k, c == 1, c == 2);
            check(16'(t2 - t1), 16'(g));
            check(16'(g ? t1 >= DLY && t1 <= DLY + 2 : t1 == 0), 16'h1);
         end
      end
      // A frozen block neither answers nor switches repeat on.
      ce = 1'b0;
      host.send(OPS[0], ME, 0);
      check(16'({host.lost, ae}), 16'h2);
      ce = 1'b1;
      print_verdict();
   end
endmodule
`default_nettype wire
